// File: hdl/tdc_cfg.svh
// register offsets, field positions, reset values and bus constants
`ifndef TDC_CFG_SVH
`define TDC_CFG_SVH

// command bytes selecting a register
`define TDC_CMD_DIVIDER 8'h5D
`define TDC_CMD_CONTROL 8'h60

// output control register fields
`define TDC_CTRL_HALF_DUTY 0
`define TDC_CTRL_FACTORY_TEST 1
`define TDC_CTRL_BASE_EN 2
`define TDC_CTRL_DIV_EN 3
`define TDC_CTRL_USED_W 4

// reset values
`define TDC_DIVIDER_RESET 8'h00
`define TDC_CONTROL_RESET 4'h0
`define TDC_POINTER_RESET 8'h00

// bus framing
`define TDC_BITS_PER_BYTE 4'h8
`define TDC_BIT_CNT_RESET 4'h0
`define TDC_SLAVE_ADDR_DEFAULT 7'h50

// enabled cycles before the synchronised strap holds the pin level
`define TDC_STRAP_SETTLE 2'h2
`define TDC_STRAP_DONE 2'h3

`endif

// File: hdl/tdc_pkg.sv
// types shared by the output divider control block
package tdc_pkg;

	// serial slave progress through a transfer
	typedef enum logic [3:0] {
		TDC_ST_IDLE,
		TDC_ST_ADDR,
		TDC_ST_ADDR_ACK,
		TDC_ST_CMD,
		TDC_ST_CMD_ACK,
		TDC_ST_WDATA,
		TDC_ST_WDATA_ACK,
		TDC_ST_RDATA,
		TDC_ST_RDATA_ACK,
		TDC_ST_IGNORE
	} tdc_bus_state_t;

endpackage

// File: hdl/tdc_sync.sv
// two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module tdc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	// first stage feeds only the second
	always_comb begin
		meta_d = meta_q;
		sync_d = sync_q;
		if (clk_en) begin
			meta_d = async_in;
			sync_d = meta_q;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			meta_q <= '1;
			sync_q <= '1;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;

endmodule

// File: hdl/tdc_clock_divider.sv
// programmable integer divider of the base clock
`timescale 1ns/1ps
module tdc_clock_divider #(
	parameter int WIDTH = 8
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic enable,
	input wire logic half_duty,
	input wire logic [WIDTH-1:0] ratio,
	output logic wave_out
);

	logic [WIDTH-1:0] cnt_q;
	logic [WIDTH-1:0] cnt_d;
	logic wave_q;
	logic wave_d;
	logic wrap;

	// count 0..ratio, giving a period of ratio+1 base cycles
	always_comb begin
		cnt_d = cnt_q;
		wave_d = wave_q;
		wrap = (cnt_q == ratio);
		if (clk_en) begin
			if (!enable) begin
				cnt_d = '0;
				wave_d = 1'b0;
			end else begin
				cnt_d = wrap ? '0 : cnt_q + 1'b1;
				if (half_duty) begin
					// toggle each period: divide by 2(n+1), 50% duty
					wave_d = wrap ? ~wave_q : wave_q;
				end else begin
					// high for the first half of each n+1 period
					wave_d = (cnt_d <= (ratio >> 1));
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cnt_q <= '0;
			wave_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			wave_q <= wave_d;
		end
	end

	assign wave_out = wave_q;

endmodule

// File: hdl/tdc_output_control.sv
// output divider control: clock outputs, register bank and 2-wire slave
//
// Function
// - base clock output is the undivided base clock, gated by its enable
// - divided output is base/(n+1), or base/2(n+1) with half duty set
// - eight-bit divider value register, reset to zero
// - control bit 0 selects half duty, 50% divided output; resets to zero
// - control bit 2 enables base output, bit 3 divided output; reset zero
// - slave address low bit follows the sampled address select pin
// - serial data is open drain: pull low or release only
// - serial clock only times transfers; up to 400 kHz supported
// - outputs run with no bus activity; bus only reaches registers
// - command 5Dh selects divider, 60h control, then one data byte
// - register pointer never advances; a read without a command reuses the last one
`timescale 1ns/1ps
`include "tdc_cfg.svh"
module tdc_output_control
	import tdc_pkg::*;
#(
	parameter logic [6:0] SLAVE_ADDR_BASE = `TDC_SLAVE_ADDR_DEFAULT
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic address_select_pin,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic base_clock_out,
	output logic divided_clock_out
);

	// synchronised pins
	logic scl_s;
	logic sda_s;
	logic addr_s;
	logic scl_p_q;
	logic sda_p_q;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	// strap capture
	logic addr_sel_q;
	logic addr_sel_d;
	logic [1:0] strap_cnt_q;
	logic [1:0] strap_cnt_d;

	// registers
	logic [7:0] divider_value_q;
	logic [7:0] divider_value_d;
	logic [3:0] control_q;
	logic [3:0] control_d;
	logic [7:0] ptr_q;
	logic [7:0] ptr_d;

	// serial engine
	tdc_bus_state_t state_q;
	tdc_bus_state_t state_d;
	logic [3:0] bit_cnt_q;
	logic [3:0] bit_cnt_d;
	logic [7:0] shift_q;
	logic [7:0] shift_d;
	logic [7:0] shift_next;
	logic rw_q;
	logic rw_d;
	logic sda_oe_q;
	logic sda_oe_d;
	logic byte_done;
	logic addr_hit;
	logic [7:0] read_data;

	// clock gating
	logic base_gate_q;
	logic div_gate_q;
	logic div_wave;
	logic div_bypass;

	// control fields
	logic half_duty_select;
	logic base_out_enable;
	logic divided_out_enable;

	assign half_duty_select = control_q[`TDC_CTRL_HALF_DUTY];
	assign base_out_enable = control_q[`TDC_CTRL_BASE_EN];
	assign divided_out_enable = control_q[`TDC_CTRL_DIV_EN];

	// pins cross into sys_clk; sampling at 100 MHz covers 400 kHz bus
	tdc_sync #(
		.WIDTH(3)
	) u_pin_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.async_in({scl_in, sda_in, address_select_pin}),
		.sync_out({scl_s, sda_s, addr_s})
	);

	// bus edges and start/stop framing from synchronised levels
	assign scl_rise = clk_en & scl_s & ~scl_p_q;
	assign scl_fall = clk_en & ~scl_s & scl_p_q;
	assign start_det = clk_en & scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign stop_det = clk_en & scl_s & scl_p_q & ~sda_p_q & sda_s;

	assign byte_done = (bit_cnt_q == `TDC_BITS_PER_BYTE);
	assign addr_hit = (shift_q[7:1] == {SLAVE_ADDR_BASE[6:1], addr_sel_q});
	assign shift_next = {shift_q[6:0], 1'b0};

	// read data of the selected register, unused bits zero
	always_comb begin
		read_data = 8'h00;
		if (ptr_q == `TDC_CMD_DIVIDER) begin
			read_data = divider_value_q;
		end else if (ptr_q == `TDC_CMD_CONTROL) begin
			read_data = {4'h0, control_q};
		end
	end

	// strap sampled once, after the synchroniser has filled with the pin
	always_comb begin
		addr_sel_d = addr_sel_q;
		strap_cnt_d = strap_cnt_q;
		if (clk_en && strap_cnt_q != `TDC_STRAP_DONE) begin
			strap_cnt_d = strap_cnt_q + 2'h1;
			if (strap_cnt_q == `TDC_STRAP_SETTLE) begin
				addr_sel_d = addr_s;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			addr_sel_q <= 1'b0;
			strap_cnt_q <= 2'h0;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			addr_sel_q <= addr_sel_d;
			strap_cnt_q <= strap_cnt_d;
			if (clk_en) begin
				scl_p_q <= scl_s;
				sda_p_q <= sda_s;
			end
		end
	end

	// serial slave next state, register writes and data line drive
	always_comb begin
		state_d = state_q;
		bit_cnt_d = bit_cnt_q;
		shift_d = shift_q;
		rw_d = rw_q;
		sda_oe_d = sda_oe_q;
		ptr_d = ptr_q;
		divider_value_d = divider_value_q;
		control_d = control_q;
		if (start_det) begin
			// start or repeated start restarts addressing
			state_d = TDC_ST_ADDR;
			bit_cnt_d = `TDC_BIT_CNT_RESET;
			sda_oe_d = 1'b0;
		end else if (stop_det) begin
			state_d = TDC_ST_IDLE;
			sda_oe_d = 1'b0;
		end else if (scl_rise) begin
			// shift received bits on the rising edge
			unique case (state_q)
				TDC_ST_ADDR, TDC_ST_CMD, TDC_ST_WDATA: begin
					shift_d = {shift_q[6:0], sda_s};
					bit_cnt_d = bit_cnt_q + 4'h1;
				end
				TDC_ST_RDATA: begin
					bit_cnt_d = bit_cnt_q + 4'h1;
				end
				TDC_ST_IDLE, TDC_ST_ADDR_ACK, TDC_ST_CMD_ACK, TDC_ST_WDATA_ACK,
				TDC_ST_RDATA_ACK, TDC_ST_IGNORE: begin
					bit_cnt_d = bit_cnt_q;
				end
			endcase
		end else if (scl_fall) begin
			// data line changes only while the clock is low
			unique case (state_q)
				TDC_ST_ADDR: begin
					if (byte_done) begin
						if (addr_hit) begin
							rw_d = shift_q[0];
							sda_oe_d = 1'b1;
							state_d = TDC_ST_ADDR_ACK;
						end else begin
							state_d = TDC_ST_IGNORE;
						end
					end
				end
				TDC_ST_ADDR_ACK: begin
					bit_cnt_d = `TDC_BIT_CNT_RESET;
					if (rw_q) begin
						// pointer kept as set by the last command
						shift_d = read_data;
						sda_oe_d = ~read_data[7];
						state_d = TDC_ST_RDATA;
					end else begin
						sda_oe_d = 1'b0;
						state_d = TDC_ST_CMD;
					end
				end
				TDC_ST_CMD: begin
					if (byte_done) begin
						if (shift_q == `TDC_CMD_DIVIDER || shift_q == `TDC_CMD_CONTROL) begin
							ptr_d = shift_q;
							sda_oe_d = 1'b1;
							state_d = TDC_ST_CMD_ACK;
						end else begin
							// unknown command is not acknowledged
							state_d = TDC_ST_IGNORE;
						end
					end
				end
				TDC_ST_CMD_ACK: begin
					bit_cnt_d = `TDC_BIT_CNT_RESET;
					sda_oe_d = 1'b0;
					state_d = TDC_ST_WDATA;
				end
				TDC_ST_WDATA: begin
					if (byte_done) begin
						if (ptr_q == `TDC_CMD_DIVIDER) begin
							divider_value_d = shift_q;
						end else begin
							// upper bits dropped; test bit stored, no effect
							control_d = shift_q[`TDC_CTRL_USED_W-1:0];
						end
						sda_oe_d = 1'b1;
						state_d = TDC_ST_WDATA_ACK;
					end
				end
				TDC_ST_WDATA_ACK: begin
					// one data byte per command; later bytes are refused
					sda_oe_d = 1'b0;
					state_d = TDC_ST_IGNORE;
				end
				TDC_ST_RDATA: begin
					if (byte_done) begin
						sda_oe_d = 1'b0;
						state_d = TDC_ST_RDATA_ACK;
					end else begin
						shift_d = shift_next;
						sda_oe_d = ~shift_next[7];
					end
				end
				TDC_ST_RDATA_ACK: begin
					// single byte read, line already released at the start of the master ack slot
					sda_oe_d = 1'b0;
					state_d = TDC_ST_IGNORE;
				end
				TDC_ST_IDLE, TDC_ST_IGNORE: begin
					sda_oe_d = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_q <= TDC_ST_IDLE;
			bit_cnt_q <= `TDC_BIT_CNT_RESET;
			shift_q <= 8'h00;
			rw_q <= 1'b0;
			sda_oe_q <= 1'b0;
			ptr_q <= `TDC_POINTER_RESET;
			divider_value_q <= `TDC_DIVIDER_RESET;
			control_q <= `TDC_CONTROL_RESET;
		end else begin
			state_q <= state_d;
			bit_cnt_q <= bit_cnt_d;
			shift_q <= shift_d;
			rw_q <= rw_d;
			sda_oe_q <= sda_oe_d;
			ptr_q <= ptr_d;
			divider_value_q <= divider_value_d;
			control_q <= control_d;
		end
	end

	// open drain: only ever drive low
	assign sda_out = 1'b0;
	assign sda_oe = sda_oe_q;

	// divided wave runs free of the bus once programmed
	tdc_clock_divider #(
		.WIDTH(8)
	) u_divider (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.enable(divided_out_enable),
		.half_duty(half_duty_select),
		.ratio(divider_value_q),
		.wave_out(div_wave)
	);

	// gate enables move while the clock is low so pulses are never cut
	always_ff @(negedge sys_clk) begin
		if (!rst_n) begin
			base_gate_q <= 1'b0;
			div_gate_q <= 1'b0;
		end else if (clk_en) begin
			base_gate_q <= base_out_enable;
			div_gate_q <= divided_out_enable;
		end
	end

	// divide by one passes the base clock itself
	assign div_bypass = ~half_duty_select & (divider_value_q == 8'h00);

	// base output is the undivided base clock
	assign base_clock_out = sys_clk & base_gate_q;
	assign divided_clock_out = div_bypass ? (sys_clk & div_gate_q) : div_wave;

endmodule

// File: bench/tdc_output_control_chk.sv
// port assertions for the output divider control block
`timescale 1ns/1ps
module tdc_output_control_chk (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic base_clock_out,
	input wire logic divided_clock_out
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	logic [8:0] hi_q;
	logic [8:0] hi_d;
	// cycles the divided output has stayed high, counted mid-cycle where it is settled
	always_comb begin
		hi_d = hi_q;
		if (clk_en) begin
			hi_d = divided_clock_out ? hi_q + 9'h001 : 9'h000;
		end
	end
	always_ff @(negedge sys_clk) begin
		hi_q <= rst_n ? hi_d : 9'h000;
	end
	open_drain_a: assert property (sda_out == 1'b0)
		else $error("data driven high");
	ack_width_a: assert property ($rose(sda_oe) |-> sda_oe [*4])
		else $error("pull-low too short");
	oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in, 2))
		else $error("data moved near clock high");
	scl_stable_a: assert property ($rose(scl_in) |-> ##1 $stable(sda_oe) [*3])
		else $error("data moved in clock high");
	base_phase_a: assert property (!base_clock_out)
		else $error("base output high at rising edge");
	div_high_a: assert property (hi_q <= 9'h100)
		else $error("divided output high too long");
	quiet_start_a: assert property ($rose(rst_n) |-> !sda_oe [*4])
		else $error("bus driven after reset");
	freeze_hold_a: assert property (!clk_en |=> $stable(sda_oe) && $stable(divided_clock_out))
		else $error("state moved while frozen");
endmodule

bind tdc_output_control tdc_output_control_chk u_tdc_output_control_chk (.sys_clk(sys_clk), .rst_n(rst_n),
	.clk_en(clk_en), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .base_clock_out(base_clock_out),
	.divided_clock_out(divided_clock_out));

// File: bench/tdc_host_model.sv
// 2-wire bus master model for the register interface
`timescale 1ns/1ps
module tdc_host_model #(
	// quarter bit period in base cycles, about 400 kHz
	parameter int QTR = 63
) (
	input wire logic sys_clk,
	input wire logic sda,
	output logic scl,
	output logic sda_pull
);
	// idle bus: clock stands high, data released
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// start or repeated start: data falls while clock high
	task automatic start_cond();
		if (!scl) begin
			sda_pull = 1'b0;
			tick(QTR);
			scl = 1'b1;
			tick(QTR);
		end
		sda_pull = 1'b1;
		tick(QTR);
		scl = 1'b0;
		tick(QTR);
	endtask
	// one bit: data set while clock low, line sampled mid-high
	task automatic bit_io(input logic b, output logic r);
		sda_pull = !b;
		tick(QTR);
		scl = 1'b1;
		tick(QTR);
		r = sda;
		tick(QTR);
		scl = 1'b0;
		tick(QTR);
	endtask
	// msb first byte, ninth slot released by the master
	task automatic byte_io(input logic [7:0] d, output logic [7:0] r, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r[i]);
		end
		bit_io(1'b1, ack);
		ack = !ack;
	endtask
	// one transaction; acks hold address, command and write data or read address
	task automatic xfer(input logic [6:0] adr, input logic cmd_on, input logic [7:0] cmd, input logic rd,
		input logic [7:0] wd, output logic [7:0] rdat, output logic [2:0] acks);
		logic [7:0] junk;
		logic a;
		acks = 3'h0;
		start_cond();
		if (cmd_on) begin
			byte_io({adr, 1'b0}, junk, acks[2]);
			byte_io(cmd, junk, acks[1]);
			if (rd) begin
				start_cond();
			end else begin
				byte_io(wd, junk, acks[0]);
			end
		end
		if (rd) begin
			byte_io({adr, 1'b1}, junk, acks[0]);
			byte_io(8'hFF, rdat, a);
		end
		sda_pull = 1'b1;
		tick(QTR);
		scl = 1'b1;
		tick(QTR);
		sda_pull = 1'b0;
		tick(2 * QTR);
	endtask
endmodule

// File: bench/tb_tdc_output_control.sv
// self-checking bench for the output divider control block
`timescale 1ns/1ps
`include "tdc_cfg.svh"
module tb_tdc_output_control;
	localparam logic [6:0] DEV_ADR = `TDC_SLAVE_ADDR_DEFAULT | 7'h01;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic address_select_pin = 1'b1;
	logic scl, pull, sda_out, sda_oe, base_clock_out, divided_clock_out;
	logic [7:0] rd;
	logic [2:0] ak;
	int num_errors = 0;
	int num_checks = 0;
	int cycles = 0;
	int base_edges = 0;
	int div_edges = 0;
	wire sda_line = !(pull || sda_oe); // pull-up on the data line
	`define CHECK_EQ(got, exp) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
		$display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
	tdc_output_control u_tdc_output_control (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
		.address_select_pin(address_select_pin), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
		.sda_oe(sda_oe), .base_clock_out(base_clock_out), .divided_clock_out(divided_clock_out));
	tdc_host_model u_tdc_host_model (.sys_clk(sys_clk), .sda(sda_line), .scl(scl), .sda_pull(pull));
	always #5 sys_clk = ~sys_clk;
	always @(posedge base_clock_out) base_edges++;
	always @(posedge divided_clock_out) div_edges++;
	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// hang guard, a few thousand cycles above the expected run length
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 105000) begin
			num_errors++;
			print_verdict();
		end
	end
	task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
		u_tdc_host_model.xfer(DEV_ADR, 1'b1, cmd, 1'b0, d, rd, ak);
		`CHECK_EQ(ak, 3'h7)
	endtask
	task automatic rdchk(input logic cmd_on, input logic [7:0] cmd, input logic [7:0] exp);
		u_tdc_host_model.xfer(DEV_ADR, cmd_on, cmd, 1'b1, 8'hFF, rd, ak);
		`CHECK_EQ(ak, cmd_on ? 3'h7 : 3'h1)
		`CHECK_EQ(rd, exp)
	endtask
	// edges of both outputs and high samples of the divided output over 40 cycles
	task automatic meas(input int div_exp, input int hi_exp, input int base_exp);
		int hi;
		hi = 0;
		repeat (20) @(posedge sys_clk);
		#1;
		base_edges = 0;
		div_edges = 0;
		repeat (40) begin
			// an unknown level spoils the count instead of reading as low
			hi += (divided_clock_out === 1'b1) ? 1 : ((divided_clock_out === 1'b0) ? 0 : 1000);
			@(posedge sys_clk);
			#1;
		end
		`CHECK_EQ(div_edges, div_exp)
		`CHECK_EQ(hi, hi_exp)
		`CHECK_EQ(base_edges, base_exp)
	endtask
	// main sequence
	initial begin
		repeat (16) @(posedge sys_clk);
		#1;
		rst_n = 1'b1;
		repeat (8) @(posedge sys_clk);
		#1;
		rdchk(1'b1, `TDC_CMD_DIVIDER, 8'h00);
		rdchk(1'b1, `TDC_CMD_CONTROL, 8'h00);
		$display("test reset values done");
		wr(`TDC_CMD_DIVIDER, 8'h03);
		rdchk(1'b0, 8'h00, 8'h03);
		wr(`TDC_CMD_CONTROL, 8'hF1);
		rdchk(1'b1, `TDC_CMD_CONTROL, 8'h01);
		rdchk(1'b0, 8'h00, 8'h01);
		$display("test register access done");
		u_tdc_host_model.xfer(DEV_ADR, 1'b1, 8'h5E, 1'b0, 8'h00, rd, ak);
		`CHECK_EQ(ak, 3'h4)
		u_tdc_host_model.xfer(`TDC_SLAVE_ADDR_DEFAULT & 7'h7E, 1'b0, 8'h00, 1'b1, 8'hFF, rd, ak);
		`CHECK_EQ({ak, rd}, 11'h0FF)
		$display("test refusals done");
		meas(0, 0, 0);
		wr(`TDC_CMD_CONTROL, 8'h0C);
		meas(10, 20, 40);
		wr(`TDC_CMD_CONTROL, 8'h0D);
		meas(5, 20, 40);
		wr(`TDC_CMD_DIVIDER, 8'h00);
		meas(20, 20, 40);
		wr(`TDC_CMD_CONTROL, 8'h08);
		meas(40, 40, 0);
		$display("test outputs done");
		clk_en = 1'b0;
		repeat (20) @(posedge sys_clk);
		#1;
		clk_en = 1'b1;
		rdchk(1'b0, 8'h00, 8'h08);
		$display("test freeze done");
		print_verdict();
	end
endmodule
